// ===== ddsr_regs.sv
`default_nettype none
// Functional notes
// - Inhibit bit freezes bus address during transfers
// - Drive answers only when select matches plug
// - Attention raises special condition; clears on clears
// - Command load clears attention unless errors
// - Error summary ORs error registers, forces attention
// - Errors block all commands except drive clear
// - Positioning bit set during positioning commands
// - Medium on-line change sets attention, requests interrupt
// - Write lock bit mirrors write-protect switch
// - Last sector bit set at final sector
// - Report dual port, power and ready
// - Volume valid clears on-line, sets on acknowledge
// - Latch head-load events until file ready
// - Any error one bit sets error summary
// - Error bits clear on zero write, clears
// - Data check and uncorrectable ECC errors
// - Unsafe bit follows any unsafe-class bit
// - Three index pulses without data: incomplete
// - Timing failure and missing write clocks flagged
// - Write on protected drive sets lock error
// - Invalid address and cylinder overflow errors
// - Header CRC and header compare errors
// - Controller clear clears errors, inhibit and drive select
module ddsr_regs (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_init,
  input wire logic [2:0] i_unit_plug,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [5:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  input wire logic i_cmd_load,
  input wire logic [4:0] i_cmd_code,
  output logic o_cmd_accept,
  output logic o_cmd_reject,
  input wire logic i_ba_load,
  input wire logic [15:0] i_ba_value,
  input wire logic i_xfer_word,
  output logic [15:0] o_bus_addr,
  output logic o_addr_incr_inhibit,
  output logic [2:0] o_drive_sel,
  output logic o_selected,
  output logic o_special_cond,
  output logic o_irq_req,
  output logic o_error_summary,
  input wire logic i_pin_write_prot,
  input wire logic i_pin_powered,
  input wire logic i_pin_ready,
  input wire logic i_pin_dual_port,
  input wire logic i_pin_medium_ok,
  input wire logic i_pos_done,
  input wire logic [5:0] i_headload_evt,
  input wire logic i_file_ready,
  input wire logic i_sector_done,
  input wire logic [9:0] i_cur_cyl,
  input wire logic [4:0] i_cur_trk,
  input wire logic [4:0] i_cur_sec,
  input wire logic [9:0] i_des_cyl,
  input wire logic [4:0] i_des_trk,
  input wire logic [4:0] i_des_sec,
  input wire logic i_ecc_mismatch,
  input wire logic i_ecc_hard,
  input wire logic i_timing_fail,
  input wire logic i_hdr_crc_bad,
  input wire logic i_hdr_cmp_bad,
  input wire logic i_er2_unsafe,
  input wire logic i_er2_any,
  input wire logic i_er3_any,
  input wire logic i_op_active,
  input wire logic i_index,
  input wire logic i_data_seen,
  input wire logic i_write_active,
  input wire logic i_wclk_seen
);
  typedef struct packed {
    logic aii;
    logic [2:0] sel;
    logic [2:0] unit;
    logic unit_ok;
    logic alert;
    logic es;
    logic pip;
    logic lst;
    logic vv;
    logic [5:0] hl;
    logic [10:0] flt1;
    logic mol_prev;
    logic [1:0] idx_cnt;
    logic [7:0] wclk_cnt;
    logic [15:0] bus_addr;
    logic [15:0] rdata;
    logic irq;
    logic accept;
    logic reject;
  } ddsr_state_type;

  ddsr_state_type q_r;
  ddsr_state_type q_nxt;
  logic [4:0] pins;
  logic wrp, pwr, dry, dpr, mol;
  logic sel_hit, wr_hctl, wr_drv_regs, cc, dclr, clr_all, cmd_ok;
  logic is_pos, is_xfer;
  logic [15:0] e1_set;
  logic [15:0] state_word;
  logic [15:0] e1_word;

  ddsr_pin_sync #(.W(5)) u_pin_sync (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_pin({i_pin_medium_ok, i_pin_dual_port, i_pin_ready,
            i_pin_powered, i_pin_write_prot}),
    .o_level(pins)
  );

  assign {mol, dpr, dry, pwr, wrp} = pins;

  always_comb begin
    sel_hit = q_r.unit_ok && (q_r.sel == q_r.unit);
    wr_hctl = i_reg_wr && (i_reg_addr == ddsr_pkg::OFF_HCTL);
    wr_drv_regs = i_reg_wr && sel_hit;
    cc = wr_hctl && i_reg_wdata[ddsr_pkg::HC_CLR];
    cmd_ok = i_cmd_load && sel_hit &&
             (!q_r.es || i_cmd_code == ddsr_pkg::FC_DRV_CLEAR);
    dclr = cmd_ok && (i_cmd_code == ddsr_pkg::FC_DRV_CLEAR);
    clr_all = cc || i_init || dclr;
    is_pos = (i_cmd_code == ddsr_pkg::FC_SEEK) ||
             (i_cmd_code == ddsr_pkg::FC_OFFSET) ||
             (i_cmd_code == ddsr_pkg::FC_RTC) ||
             (i_cmd_code == ddsr_pkg::FC_RECAL) ||
             (i_cmd_code == ddsr_pkg::FC_UNLOAD) ||
             (i_cmd_code == ddsr_pkg::FC_SEARCH);
    is_xfer = (i_cmd_code == ddsr_pkg::FC_WRITE) ||
              (i_cmd_code == ddsr_pkg::FC_READ);
    // Error one set sources
    e1_set = '0;
    e1_set[ddsr_pkg::E1_DCK] = i_ecc_mismatch;
    e1_set[ddsr_pkg::E1_ECH] = i_ecc_hard;
    // Timing error is unsafe-class; both bits rise on one edge
    e1_set[ddsr_pkg::E1_UNS] = i_er2_unsafe ||
      i_timing_fail;
    e1_set[ddsr_pkg::E1_OPI] = i_op_active && i_index && !i_data_seen &&
      (q_r.idx_cnt == ddsr_pkg::INDEX_LIMIT - 2'h1);
    e1_set[ddsr_pkg::E1_DTE] = i_timing_fail;
    e1_set[ddsr_pkg::E1_WCF] = i_write_active && !i_wclk_seen &&
      (q_r.wclk_cnt == ddsr_pkg::WCLK_CYC - 8'h01);
    e1_set[ddsr_pkg::E1_WLE] = cmd_ok && wrp &&
      (i_cmd_code == ddsr_pkg::FC_WRITE);
    e1_set[ddsr_pkg::E1_IAE] = cmd_ok && (is_xfer || is_pos) &&
      ((i_des_trk > ddsr_pkg::LAST_TRK) ||
       (i_des_sec > ddsr_pkg::LAST_SEC));
    e1_set[ddsr_pkg::E1_AOE] = cmd_ok && (is_xfer || is_pos) &&
      (i_des_cyl > ddsr_pkg::LAST_CYL);
    e1_set[ddsr_pkg::E1_HCRC] = i_hdr_crc_bad;
    e1_set[ddsr_pkg::E1_HCE] = i_hdr_cmp_bad;
  end

  // Register images seen by reads
  always_comb begin
    state_word = '0;
    state_word[ddsr_pkg::ST_ALERT] = q_r.alert;
    state_word[ddsr_pkg::ST_ES] = q_r.es;
    state_word[ddsr_pkg::ST_PIP] = q_r.pip;
    state_word[ddsr_pkg::ST_MOL] = mol;
    state_word[ddsr_pkg::ST_WRL] = wrp;
    state_word[ddsr_pkg::ST_LST] = q_r.lst;
    state_word[ddsr_pkg::ST_DPR] = dpr;
    state_word[ddsr_pkg::ST_PWR] = pwr;
    state_word[ddsr_pkg::ST_DRY] = dry;
    state_word[ddsr_pkg::ST_VV] = q_r.vv;
    state_word[ddsr_pkg::ST_HL_LSB +: 6] = q_r.hl;
    e1_word = {q_r.flt1, 5'h00};
  end

  always_comb begin
    q_nxt = q_r;
    q_nxt.accept = 1'b0;
    q_nxt.reject = 1'b0;
    q_nxt.irq = 1'b0;
    // Unit plug caught once after reset release
    if (!q_r.unit_ok) begin
      q_nxt.unit = i_unit_plug;
      q_nxt.unit_ok = 1'b1;
    end
    // host_control_two: inhibit and drive select
    if (wr_hctl) begin
      q_nxt.aii = i_reg_wdata[ddsr_pkg::HC_AII];
      q_nxt.sel = i_reg_wdata[ddsr_pkg::HC_SEL_LSB +: 3];
    end
    if (cc || i_init) begin
      q_nxt.aii = 1'b0;
      q_nxt.sel = 3'h0;
    end
    // Bus address stepping
    if (i_ba_load) begin
      q_nxt.bus_addr = i_ba_value;
    end else if (i_xfer_word && !q_r.aii) begin
      q_nxt.bus_addr = q_r.bus_addr + ddsr_pkg::BUS_ADDR_STEP;
    end
    // Command acceptance
    if (i_cmd_load && sel_hit) begin
      q_nxt.accept = cmd_ok;
      q_nxt.reject = !cmd_ok;
    end
    // Clears first, sets after so that a set wins
    if (i_cmd_load && sel_hit && !q_r.es) begin
      q_nxt.alert = 1'b0;
    end
    if (wr_drv_regs && i_reg_addr == ddsr_pkg::OFF_AS &&
        i_reg_wdata[q_r.unit]) begin
      q_nxt.alert = 1'b0;
    end
    if (wr_drv_regs && i_reg_addr == ddsr_pkg::OFF_FAULT1) begin
      q_nxt.flt1 = q_r.flt1 & i_reg_wdata[15:ddsr_pkg::E1_LSB];
    end
    if (clr_all) begin
      q_nxt.alert = 1'b0;
      q_nxt.es = 1'b0;
      q_nxt.flt1 = '0;
      q_nxt.lst = 1'b0;
      q_nxt.pip = 1'b0;
    end
    // Positioning in progress
    if (i_pos_done) begin
      q_nxt.pip = 1'b0;
    end
    if (cmd_ok && is_pos) begin
      q_nxt.pip = 1'b1;
    end
    // Last sector transferred
    if (i_sector_done && i_cur_cyl == ddsr_pkg::LAST_CYL &&
        i_cur_trk == ddsr_pkg::LAST_TRK &&
        i_cur_sec == ddsr_pkg::LAST_SEC) begin
      q_nxt.lst = 1'b1;
    end
    // Head-load event latches
    if (i_file_ready) begin
      q_nxt.hl = '0;
    end
    q_nxt.hl = q_nxt.hl | i_headload_evt;
    // Volume valid and medium on-line change
    q_nxt.mol_prev = mol;
    if (mol && !q_r.mol_prev) begin
      q_nxt.vv = 1'b0;
    end
    if (cmd_ok && (i_cmd_code == ddsr_pkg::FC_PACK_ACK ||
                   i_cmd_code == ddsr_pkg::FC_PRESET)) begin
      q_nxt.vv = 1'b1;
    end
    if (mol != q_r.mol_prev) begin
      q_nxt.alert = 1'b1;
      q_nxt.irq = 1'b1;
    end
    // Index pulse counter for operation incomplete
    if (!i_op_active || i_data_seen) begin
      q_nxt.idx_cnt = 2'h0;
    end else if (i_index && q_r.idx_cnt != ddsr_pkg::INDEX_LIMIT) begin
      q_nxt.idx_cnt = q_r.idx_cnt + 2'h1;
    end
    // Write clock watchdog
    if (!i_write_active || i_wclk_seen) begin
      q_nxt.wclk_cnt = 8'h00;
    end else if (q_r.wclk_cnt != ddsr_pkg::WCLK_CYC) begin
      q_nxt.wclk_cnt = q_r.wclk_cnt + 8'h01;
    end
    // Error bits and summary; a clear also drops what it clears
    q_nxt.flt1 = q_nxt.flt1 | e1_set[15:ddsr_pkg::E1_LSB];
    if (((|q_r.flt1) && !clr_all) || i_er2_any || i_er3_any) begin
      q_nxt.es = 1'b1;
    end
    if (q_r.es && !clr_all) begin
      q_nxt.alert = 1'b1;
    end
    // Read data; drive registers answer only when selected
    if (i_reg_rd) begin
      q_nxt.rdata = 16'h0000;
      if (i_reg_addr == ddsr_pkg::OFF_HCTL) begin
        q_nxt.rdata[ddsr_pkg::HC_AII] = q_r.aii;
        q_nxt.rdata[ddsr_pkg::HC_SEL_LSB +: 3] = q_r.sel;
      end else if (sel_hit && i_reg_addr == ddsr_pkg::OFF_STATE) begin
        q_nxt.rdata = state_word;
      end else if (sel_hit && i_reg_addr == ddsr_pkg::OFF_FAULT1) begin
        q_nxt.rdata = e1_word;
      end else if (sel_hit && i_reg_addr == ddsr_pkg::OFF_AS) begin
        q_nxt.rdata[q_r.unit] = q_r.alert;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_reg_rdata = q_r.rdata;
  assign o_cmd_accept = q_r.accept;
  assign o_cmd_reject = q_r.reject;
  assign o_bus_addr = q_r.bus_addr;
  assign o_addr_incr_inhibit = q_r.aii;
  assign o_drive_sel = q_r.sel;
  assign o_selected = sel_hit;
  assign o_special_cond = q_r.alert;
  assign o_irq_req = q_r.irq;
  assign o_error_summary = q_r.es;

  chk_aii_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (cc || i_init) |=> !o_addr_incr_inhibit)
    else $error("Inhibit bit survived a clear");

  chk_addr_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (q_r.aii && !wr_hctl && !cc && !i_init && i_xfer_word && !i_ba_load)
    |=> $stable(o_bus_addr))
    else $error("Bus address moved while inhibited");

  chk_es_special: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (q_r.es && !clr_all) |=> o_special_cond)
    else $error("Error summary did not force attention");

  chk_cmd_reject: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (q_r.es && i_cmd_load && sel_hit &&
     i_cmd_code != ddsr_pkg::FC_DRV_CLEAR)
    |=> (o_cmd_reject && !o_cmd_accept))
    else $error("Command accepted under error summary");

  chk_mol_alert: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (mol != q_r.mol_prev) |=> (o_irq_req && q_r.alert))
    else $error("On-line change gave no attention");

  chk_last_sector: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_sector_done && i_cur_cyl == ddsr_pkg::LAST_CYL &&
     i_cur_trk == ddsr_pkg::LAST_TRK && i_cur_sec == ddsr_pkg::LAST_SEC)
    |=> q_r.lst)
    else $error("Last sector not flagged");

  chk_flt1_summary: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    ((|q_r.flt1) && !clr_all) |=> q_r.es)
    else $error("Error bit did not raise summary");

  chk_zero_write: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (wr_drv_regs && i_reg_addr == ddsr_pkg::OFF_FAULT1 &&
     i_reg_wdata == 16'h0000 && e1_set == 16'h0000)
    |=> (q_r.flt1 == 11'h000))
    else $error("Zero write left error bits set");

  chk_pip_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (cmd_ok && is_pos) |=> q_r.pip)
    else $error("Positioning bit not set");

  chk_wclk_fail: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_write_active && !i_wclk_seen)[*8] |-> ##[0:40]
    (q_r.flt1[ddsr_pkg::E1_WCF - ddsr_pkg::E1_LSB] || !i_write_active ||
     i_wclk_seen || clr_all))
    else $error("Missing write clocks not flagged");
endmodule
`default_nettype wire

// ===== ddsr_pkg.sv
`default_nettype none
package ddsr_pkg;
  // Register offsets on the drive register port
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFF_HCTL = 6'h3c;
  localparam logic [5:0] OFF_STATE = 6'h04;
  localparam logic [5:0] OFF_FAULT1 = 6'h08;
  localparam logic [5:0] OFF_AS = 6'h10;
  // host_control_two fields
  localparam int HC_CLR = 5;
  localparam int HC_AII = 3;
  localparam int HC_SEL_LSB = 0;
  // drive_state_word fields
  localparam int ST_ALERT = 15;
  localparam int ST_ES = 14;
  localparam int ST_PIP = 13;
  localparam int ST_MOL = 12;
  localparam int ST_WRL = 11;
  localparam int ST_LST = 10;
  localparam int ST_DPR = 9;
  localparam int ST_PWR = 8;
  localparam int ST_DRY = 7;
  localparam int ST_VV = 6;
  localparam int ST_HL_LSB = 0;
  // fault_word_one fields, stored bits 15 down to 05
  localparam int E1_LSB = 5;
  localparam int E1_DCK = 15;
  localparam int E1_UNS = 14;
  localparam int E1_OPI = 13;
  localparam int E1_DTE = 12;
  localparam int E1_WLE = 11;
  localparam int E1_IAE = 10;
  localparam int E1_AOE = 9;
  localparam int E1_HCRC = 8;
  localparam int E1_HCE = 7;
  localparam int E1_ECH = 6;
  localparam int E1_WCF = 5;
  // Bus address reset value and step
  localparam logic [15:0] BUS_ADDR_RST = 16'h0000;
  localparam logic [15:0] BUS_ADDR_STEP = 16'h0002;
  // Function codes, bits 05-01 of the first control register
  localparam logic [4:0] FC_UNLOAD = 5'h01;
  localparam logic [4:0] FC_SEEK = 5'h02;
  localparam logic [4:0] FC_RECAL = 5'h03;
  localparam logic [4:0] FC_DRV_CLEAR = 5'h04;
  localparam logic [4:0] FC_OFFSET = 5'h06;
  localparam logic [4:0] FC_RTC = 5'h07;
  localparam logic [4:0] FC_PRESET = 5'h08;
  localparam logic [4:0] FC_PACK_ACK = 5'h09;
  localparam logic [4:0] FC_SEARCH = 5'h0c;
  localparam logic [4:0] FC_WRITE = 5'h18;
  localparam logic [4:0] FC_READ = 5'h1c;
  // Geometry limits
  localparam logic [9:0] LAST_CYL = 10'h32e;
  localparam logic [4:0] LAST_TRK = 5'h12;
  localparam logic [4:0] LAST_SEC = 5'h15;
  // Timing
  localparam logic [1:0] INDEX_LIMIT = 2'h3;
  localparam int CLK_NS = 50;
  localparam int WCLK_TIMEOUT_NS = 2000;
  localparam logic [7:0] WCLK_CYC =
    8'((WCLK_TIMEOUT_NS + CLK_NS - 1) / CLK_NS);
endpackage
`default_nettype wire

// ===== ddsr_pin_sync.sv
`default_nettype none
module ddsr_pin_sync #(
  parameter int W = 5
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ddsr_sync_type;

  ddsr_sync_type st_r;
  ddsr_sync_type st_nxt;

  // A change counts once the second and third stages agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.q = (st_r.s2 & st_r.s3) | (st_r.q & (st_r.s2 ^ st_r.s3));
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.q;

  chk_sync_agree: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (st_r.s2 == st_r.s3) |=> (st_r.q == $past(st_r.s3)))
    else $error("Synchroniser output ignored agreeing stages");
endmodule
`default_nettype wire

// ===== ddsr_ctl_model.sv
`default_nettype none
module ddsr_ctl_model (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_write_active,
  input wire logic i_stall,
  output logic o_wclk_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph_r;
  // Write clocks every fourth cycle while a write runs and i_stall is low
  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      ph_r <= 2'h0;
      o_wclk_seen <= 1'b0;
    end else begin
      ph_r <= ph_r + 2'h1;
      o_wclk_seen <= i_write_active && !i_stall && (ph_r == 2'h0);
    end
  end
endmodule
`default_nettype wire

// ===== disk_drive_status_error_regs_tb.sv
`default_nettype none
module disk_drive_status_error_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk, i_rst_b, i_init, i_reg_wr, i_reg_rd, i_cmd_load, i_ba_load;
  logic [2:0] i_unit_plug;
  logic [5:0] i_reg_addr, i_headload_evt;
  logic [15:0] i_reg_wdata, o_reg_rdata, i_ba_value, o_bus_addr;
  logic [4:0] i_cmd_code, i_cur_trk, i_cur_sec, i_des_trk, i_des_sec;
  logic o_cmd_accept, o_cmd_reject, i_xfer_word, o_addr_incr_inhibit;
  logic [2:0] o_drive_sel;
  logic o_selected, o_special_cond, o_irq_req, o_error_summary;
  logic i_pin_write_prot, i_pin_powered, i_pin_ready, i_pin_dual_port;
  logic i_pin_medium_ok, i_pos_done, i_file_ready, i_sector_done;
  logic [9:0] i_cur_cyl, i_des_cyl;
  logic i_ecc_mismatch, i_ecc_hard, i_timing_fail, i_hdr_crc_bad;
  logic i_hdr_cmp_bad, i_er2_unsafe, i_er2_any, i_er3_any, i_op_active;
  logic i_index, i_data_seen, i_write_active, i_wclk_seen, stall;
  int fails, cmp_count, irq_cnt;
  localparam logic [15:0] EXP_E [6] = '{16'h8000, 16'h0040, 16'h0100,
    16'h0080, 16'h5000, 16'h0000};
  logic [4:0] pos_fc [6];
  ddsr_regs dut (.i_mclk, .i_rst_b, .i_init, .i_unit_plug, .i_reg_wr,
    .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_cmd_load,
    .i_cmd_code, .o_cmd_accept, .o_cmd_reject, .i_ba_load, .i_ba_value,
    .i_xfer_word, .o_bus_addr, .o_addr_incr_inhibit, .o_drive_sel,
    .o_selected, .o_special_cond, .o_irq_req, .o_error_summary,
    .i_pin_write_prot, .i_pin_powered, .i_pin_ready, .i_pin_dual_port,
    .i_pin_medium_ok, .i_pos_done, .i_headload_evt, .i_file_ready,
    .i_sector_done, .i_cur_cyl, .i_cur_trk, .i_cur_sec, .i_des_cyl,
    .i_des_trk, .i_des_sec, .i_ecc_mismatch, .i_ecc_hard, .i_timing_fail,
    .i_hdr_crc_bad, .i_hdr_cmp_bad, .i_er2_unsafe, .i_er2_any, .i_er3_any,
    .i_op_active, .i_index, .i_data_seen, .i_write_active, .i_wclk_seen);
  ddsr_ctl_model partner (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_write_active(i_write_active), .i_stall(stall),
    .o_wclk_seen(i_wclk_seen));
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    if (o_irq_req === 1'b1) irq_cnt <= irq_cnt + 1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #5;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0, got}, {15'h0, exp});
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    tick(1);
    i_reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [15:0] m,
    input logic [15:0] e);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    tick(1);
    i_reg_rd = 1'b0;
    chk16(o_reg_rdata & m, e);
    tick(1);
  endtask
  task automatic cmd(input logic [4:0] c, input logic acc);
    i_cmd_load = 1'b1;
    i_cmd_code = c;
    tick(1);
    i_cmd_load = 1'b0;
    chk1(o_cmd_accept, acc);
    chk1(o_cmd_reject, !acc);
    tick(1);
  endtask
  task automatic inject(input int k);
    {i_ecc_mismatch, i_ecc_hard, i_hdr_crc_bad, i_hdr_cmp_bad,
      i_timing_fail, i_er3_any} = 6'h20 >> k;
    tick(1);
    {i_ecc_mismatch, i_ecc_hard, i_hdr_crc_bad, i_hdr_cmp_bad,
      i_timing_fail, i_er3_any} = 6'h00;
    tick(2);
  endtask
  task automatic strobe_index(input int n);
    repeat (n) begin
      i_index = 1'b1;
      tick(1);
      i_index = 1'b0;
      tick(3);
    end
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    print_verdict();
  end
  initial begin
    {i_init, i_reg_wr, i_reg_rd, i_cmd_load, i_ba_load, i_xfer_word} = '0;
    {i_pos_done, i_file_ready, i_sector_done, i_ecc_mismatch} = '0;
    {i_ecc_hard, i_timing_fail, i_hdr_crc_bad, i_hdr_cmp_bad} = '0;
    {i_er2_unsafe, i_er2_any, i_er3_any, i_op_active, i_index} = '0;
    {i_data_seen, i_write_active, stall, i_pin_medium_ok} = '0;
    {i_pin_write_prot, i_pin_powered, i_pin_ready, i_pin_dual_port} = '1;
    i_rst_b = 1'b0;
    i_unit_plug = 3'h5;
    i_reg_addr = 6'h00;
    i_reg_wdata = 16'h0000;
    i_cmd_code = 5'h00;
    i_ba_value = 16'h0000;
    i_headload_evt = 6'h00;
    {i_cur_cyl, i_cur_trk, i_cur_sec, i_des_cyl, i_des_trk, i_des_sec} = '0;
    fails = 0;
    cmp_count = 0;
    irq_cnt = 0;
    pos_fc = '{ddsr_pkg::FC_SEEK, ddsr_pkg::FC_OFFSET, ddsr_pkg::FC_RTC,
      ddsr_pkg::FC_RECAL, ddsr_pkg::FC_UNLOAD, ddsr_pkg::FC_SEARCH};
    tick(4);
    i_rst_b = 1'b1;
    tick(2);
    chk1(o_selected, 1'b0);
    wr(6'h3c, 16'h0005);
    chk16({13'h0, o_drive_sel}, 16'h0005);
    chk1(o_selected, 1'b1);
    rdchk(6'h04, 16'h0b80, 16'h0b80);
    wr(6'h04, 16'hffff);
    rdchk(6'h04, 16'hffff, 16'h0b80);
    wr(6'h3c, 16'h0004);
    rdchk(6'h04, 16'hffff, 16'h0000);
    wr(6'h3c, 16'h0005);
    // Pack comes on-line, then goes off and on again
    i_pin_medium_ok = 1'b1;
    tick(8);
    chk16(16'(irq_cnt), 16'h0001);
    chk1(o_special_cond, 1'b1);
    rdchk(6'h04, 16'h9040, 16'h9000);
    cmd(ddsr_pkg::FC_PACK_ACK, 1'b1);
    rdchk(6'h04, 16'h8040, 16'h0040);
    i_pin_medium_ok = 1'b0;
    tick(8);
    chk1(o_special_cond, 1'b1);
    wr(6'h10, 16'h0020);
    chk1(o_special_cond, 1'b0);
    i_pin_medium_ok = 1'b1;
    tick(8);
    chk16(16'(irq_cnt), 16'h0003);
    rdchk(6'h04, 16'h0040, 16'h0000);
    cmd(ddsr_pkg::FC_PRESET, 1'b1);
    rdchk(6'h04, 16'h0040, 16'h0040);
    // Bus address stepping with and without inhibit
    i_ba_value = 16'h1000;
    i_ba_load = 1'b1;
    tick(1);
    i_ba_load = 1'b0;
    i_xfer_word = 1'b1;
    tick(1);
    i_xfer_word = 1'b0;
    tick(1);
    chk16(o_bus_addr, 16'h1002);
    wr(6'h3c, 16'h000d);
    chk1(o_addr_incr_inhibit, 1'b1);
    rdchk(6'h3c, 16'h000f, 16'h000d);
    i_xfer_word = 1'b1;
    tick(2);
    i_xfer_word = 1'b0;
    tick(1);
    chk16(o_bus_addr, 16'h1002);
    wr(6'h3c, 16'h0005);
    chk1(o_addr_incr_inhibit, 1'b0);
    foreach (pos_fc[i]) begin
      cmd(pos_fc[i], 1'b1);
      rdchk(6'h04, 16'h2000, 16'h2000);
      i_pos_done = 1'b1;
      tick(1);
      i_pos_done = 1'b0;
      tick(1);
      rdchk(6'h04, 16'h2000, 16'h0000);
    end
    i_headload_evt = 6'h3f;
    tick(1);
    i_headload_evt = 6'h00;
    tick(1);
    rdchk(6'h04, 16'h003f, 16'h003f);
    i_file_ready = 1'b1;
    tick(1);
    i_file_ready = 1'b0;
    tick(1);
    rdchk(6'h04, 16'h003f, 16'h0000);
    {i_cur_cyl, i_cur_trk, i_cur_sec} = {ddsr_pkg::LAST_CYL, 5'h12, 5'h14};
    for (int s = 0; s < 2; s++) begin
      i_sector_done = 1'b1;
      tick(1);
      i_sector_done = 1'b0;
      tick(1);
      rdchk(6'h04, 16'h0400, s == 1 ? 16'h0400 : 16'h0000);
      i_cur_sec = 5'h15;
    end
    for (int k = 0; k < 6; k++) begin
      inject(k);
      rdchk(6'h08, 16'hffe0, EXP_E[k]);
      chk1(o_error_summary, 1'b1);
      chk1(o_special_cond, 1'b1);
      cmd(ddsr_pkg::FC_SEEK, 1'b0);
      wr(6'h08, 16'h0000);
      rdchk(6'h08, 16'hffe0, 16'h0000);
      chk1(o_error_summary, 1'b1);
      cmd(ddsr_pkg::FC_DRV_CLEAR, 1'b1);
      chk1(o_error_summary, 1'b0);
    end
    {i_er2_unsafe, i_er2_any} = 2'h3;
    tick(3);
    rdchk(6'h08, 16'h4000, 16'h4000);
    {i_er2_unsafe, i_er2_any} = 2'h0;
    cmd(ddsr_pkg::FC_DRV_CLEAR, 1'b1);
    rdchk(6'h08, 16'hffe0, 16'h0000);
    i_op_active = 1'b1;
    strobe_index(2);
    i_data_seen = 1'b1;
    tick(1);
    i_data_seen = 1'b0;
    strobe_index(2);
    rdchk(6'h08, 16'h2000, 16'h0000);
    strobe_index(1);
    rdchk(6'h08, 16'h2000, 16'h2000);
    i_op_active = 1'b0;
    cmd(ddsr_pkg::FC_DRV_CLEAR, 1'b1);
    i_des_cyl = 10'h32f;
    cmd(ddsr_pkg::FC_SEEK, 1'b1);
    rdchk(6'h08, 16'h0200, 16'h0200);
    cmd(ddsr_pkg::FC_DRV_CLEAR, 1'b1);
    {i_des_cyl, i_des_sec} = {10'h000, 5'h16};
    cmd(ddsr_pkg::FC_READ, 1'b1);
    rdchk(6'h08, 16'h0600, 16'h0400);
    cmd(ddsr_pkg::FC_DRV_CLEAR, 1'b1);
    i_des_sec = 5'h00;
    cmd(ddsr_pkg::FC_WRITE, 1'b1);
    rdchk(6'h08, 16'h0800, 16'h0800);
    cmd(ddsr_pkg::FC_DRV_CLEAR, 1'b1);
    i_write_active = 1'b1;
    tick(60);
    rdchk(6'h08, 16'h0020, 16'h0000);
    stall = 1'b1;
    tick(60);
    rdchk(6'h08, 16'h0020, 16'h0020);
    {i_write_active, stall} = 2'h0;
    wr(6'h3c, 16'h0025);
    rdchk(6'h08, 16'hffe0, 16'h0000);
    chk1(o_error_summary, 1'b0);
    chk16({13'h0, o_drive_sel}, 16'h0000);
    wr(6'h3c, 16'h000d);
    rdchk(6'h08, 16'hffe0, 16'h0000);
    inject(0);
    i_init = 1'b1;
    tick(1);
    i_init = 1'b0;
    tick(1);
    chk1(o_error_summary, 1'b0);
    chk1(o_addr_incr_inhibit, 1'b0);
    chk1(o_special_cond, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
